// File: bid_defs.svh
// Constants for the jump and increment decode block
`ifndef BID_DEFS_SVH
`define BID_DEFS_SVH
// ****************************************
// Instruction fields
// ****************************************
`define INSTR_W 14
`define PC_W 13
`define DATA_W 8
`define FADDR_W 7
`define LATCH_W 5
`define JUMP_OP_MSB 13
`define JUMP_OP_LSB 11
`define JUMP_OP 3'h5
`define ALU_OP_MSB 13
`define ALU_OP_LSB 8
`define INCR_SKIP_OP 6'h0f
`define INCR_OP 6'h0a
`define DEST_BIT 7
`define TARGET_MSB 10
`define LATCH_PAGE_MSB 4
`define LATCH_PAGE_LSB 3
`define DATA_ONE 8'h01
`define DATA_ZERO 8'h00
`define PC_RESET 13'h0000
`endif

// File: bid_pkg.sv
// Types for the jump and increment decode block
package bid_pkg;
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_NOP = 1'b1
  } step_state_t;
endpackage

// File: branch_and_increment_decode.sv
// Decode and execute of the jump and both increment instructions
`timescale 1ns/1ps
`default_nettype none
`include "bid_defs.svh"
module branch_and_increment_decode import bid_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Instruction step
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [`INSTR_W-1:0] instr_word,
  input wire logic [`LATCH_W-1:0] upper_page_latch,
  // Register file read
  output logic [`FADDR_W-1:0] reg_raddr,
  input wire logic [`DATA_W-1:0] reg_rdata,
  // Results
  output logic reg_we_reg,
  output logic [`FADDR_W-1:0] reg_waddr_reg,
  output logic [`DATA_W-1:0] result_reg,
  output logic wacc_we_reg,
  output logic zero_we_reg,
  output logic zero_val_reg,
  output logic pc_load_reg,
  output logic [`PC_W-1:0] pc_target_reg,
  output logic discard_reg,
  output logic unknown_reg
);

  // ****************************************
  // Decode
  // ****************************************
  step_state_t state_reg;
  step_state_t state_next;
  logic take;
  logic [`JUMP_OP_MSB-`JUMP_OP_LSB:0] jump_field;
  logic [`ALU_OP_MSB-`ALU_OP_LSB:0] alu_field;
  logic [`TARGET_MSB:0] jump_imm;
  logic [`LATCH_PAGE_MSB-`LATCH_PAGE_LSB:0] page_bits;
  logic [`FADDR_W-1:0] reg_field;
  logic is_jump;
  logic is_incr_skip;
  logic is_incr;
  logic is_incr_any;
  logic dest_reg_sel;
  logic [`DATA_W-1:0] sum;
  logic sum_zero;
  logic skip;
  logic load_jump;
  logic load_incr;
  logic load_zero;
  logic write_reg;
  logic write_acc;

  // A second cycle is always a bubble, so nothing is taken during it
  assign instr_ready = (state_reg == ST_RUN);
  assign take = instr_valid && instr_ready;

  // ****************************************
  // Field split
  // ****************************************
  // Slices are taken once so every consumer agrees on them
  assign jump_field = instr_word[`JUMP_OP_MSB:`JUMP_OP_LSB];
  assign alu_field = instr_word[`ALU_OP_MSB:`ALU_OP_LSB];
  assign jump_imm = instr_word[`TARGET_MSB:0];
  assign page_bits = upper_page_latch[`LATCH_PAGE_MSB:`LATCH_PAGE_LSB];
  assign reg_field = instr_word[`FADDR_W-1:0];
  assign dest_reg_sel = instr_word[`DEST_BIT];

  // ****************************************
  // Opcode match
  // ****************************************
  // Jump matches on three bits only; the immediate is never inspected
  assign is_jump = (jump_field == `JUMP_OP);
  assign is_incr_skip = (alu_field == `INCR_SKIP_OP);
  assign is_incr = (alu_field == `INCR_OP);
  assign is_incr_any = is_incr_skip || is_incr;
  assign load_jump = take && is_jump;
  assign load_incr = take && is_incr_any;
  assign load_zero = take && is_incr;

  // ****************************************
  // Operand and result
  // ****************************************
  // Read address is combinational so the operand is ready the same cycle
  assign reg_raddr = reg_field;
  // The carry out is dropped; only the wrap to zero matters
  assign sum = reg_rdata + `DATA_ONE;
  assign sum_zero = (sum == `DATA_ZERO);
  assign skip = take && is_incr_skip && sum_zero;

  // ****************************************
  // Destination select
  // ****************************************
  assign write_reg = load_incr && dest_reg_sel;
  assign write_acc = load_incr && !dest_reg_sel;

  // ****************************************
  // Step sequencing
  // ****************************************
  always_comb begin
    case (state_reg)
      ST_RUN: begin
        if (take && (is_jump || skip)) begin
          state_next = ST_NOP;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_NOP: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Program counter load
  // ****************************************
  // The fetch unit loads its counter on this strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_load_reg <= 1'b0;
    end else begin
      pc_load_reg <= load_jump;
    end
  end

  // Target holds between jumps so a late reader still sees it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_target_reg <= `PC_RESET;
    end else if (load_jump) begin
      pc_target_reg <= {page_bits, jump_imm};
    end
  end

  // ****************************************
  // Discard of the word behind
  // ****************************************
  // A jump and a zero skip both cost the word already fetched
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      discard_reg <= 1'b0;
    end else begin
      discard_reg <= load_jump || skip;
    end
  end

  // ****************************************
  // Write strobes
  // ****************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_we_reg <= 1'b0;
    end else begin
      reg_we_reg <= write_reg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wacc_we_reg <= 1'b0;
    end else begin
      wacc_we_reg <= write_acc;
    end
  end

  // ****************************************
  // Write address and result
  // ****************************************
  // Both hold until the next increment, so a slow writer is safe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_waddr_reg <= {`FADDR_W{1'b0}};
    end else if (load_incr) begin
      reg_waddr_reg <= reg_field;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= `DATA_ZERO;
    end else if (load_incr) begin
      result_reg <= sum;
    end
  end

  // ****************************************
  // Zero flag
  // ****************************************
  // Only the plain increment touches the flag; jump and skip leave it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      zero_we_reg <= 1'b0;
    end else begin
      zero_we_reg <= load_zero;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      zero_val_reg <= 1'b0;
    end else if (load_zero) begin
      zero_val_reg <= sum_zero;
    end
  end

  // ****************************************
  // Unhandled words
  // ****************************************
  // Other opcodes belong to the rest of the core; this only flags them
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      unknown_reg <= 1'b0;
    end else begin
      unknown_reg <= take && !is_jump && !is_incr_any;
    end
  end

endmodule
`default_nettype wire

// File: bid_props.sv
// Checker for the jump and increment decode block
`timescale 1ns/1ps
`default_nettype none
module bid_props (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Step and operands
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [13:0] instr_word,
  input wire logic [4:0] upper_page_latch,
  input wire logic [7:0] reg_rdata,
  // Results
  input wire logic [7:0] result_reg,
  input wire logic reg_we_reg,
  input wire logic wacc_we_reg,
  input wire logic zero_we_reg,
  input wire logic zero_val_reg,
  input wire logic pc_load_reg,
  input wire logic discard_reg,
  input wire logic [12:0] pc_target_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire tk = instr_valid && instr_ready;
  wire jmp = tk && instr_word[13:11] == 3'h5;
  wire isz = tk && instr_word[13:8] == 6'h0f;
  wire inc = tk && instr_word[13:8] == 6'h0a;
  AST_JUMP_FLAGS: assert property (jmp |=> !zero_we_reg)
    else $error("jump wrote zero flag");
  AST_JUMP_TGT: assert property (jmp |=> pc_load_reg &&
    pc_target_reg == {$past(upper_page_latch[4:3]), $past(instr_word[10:0])})
    else $error("bad jump target");
  AST_JUMP_TWO: assert property (jmp |=> !instr_ready ##1 instr_ready)
    else $error("jump not two cycles");
  AST_SKIP_ADD: assert property (isz |=> !zero_we_reg &&
    result_reg == $past(reg_rdata) + 8'h01)
    else $error("bad skip increment");
  AST_SKIP_ZERO: assert property (isz |=> discard_reg ==
    (result_reg == 8'h00) && instr_ready != discard_reg)
    else $error("bad skip decision");
  AST_DEST: assert property (isz || inc |=>
    reg_we_reg == $past(instr_word[7]) && wacc_we_reg != reg_we_reg)
    else $error("bad destination");
  AST_INC_ONE: assert property (inc |=> !discard_reg && instr_ready)
    else $error("increment skipped");
  AST_INC_ZERO: assert property (inc |=> zero_we_reg &&
    zero_val_reg == ($past(reg_rdata) == 8'hff))
    else $error("bad zero flag");
  cover property (jmp);
  cover property (isz ##1 discard_reg);
  cover property (inc ##1 zero_val_reg);
endmodule
bind branch_and_increment_decode bid_props props (.*);
`default_nettype wire

// File: branch_and_increment_decode_tb_top.sv
// Testbench for the jump and increment decode block
`timescale 1ns/1ps
`default_nettype none
module branch_and_increment_decode_tb_top;
  logic clock = 0, arst_n = 0, instr_valid = 0;
  logic [13:0] instr_word = 0;
  logic [4:0] upper_page_latch = 0;
  logic [7:0] reg_rdata = 0;
  wire instr_ready, reg_we_reg, wacc_we_reg, zero_we_reg, zero_val_reg;
  wire pc_load_reg, discard_reg, unknown_reg;
  wire [6:0] reg_raddr, reg_waddr_reg;
  wire [7:0] result_reg;
  wire [12:0] pc_target_reg;
  int n_errors = 0, checks_done = 0;
  always #5 clock = ~clock;
  branch_and_increment_decode dut (.*);
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Offer one word, judge the step after it is taken
  task automatic op(logic [13:0] w, logic [7:0] d, logic [7:0] r, logic sk);
    logic jp;
    logic ic;
    jp = (w[13:11] == 3'h5);
    ic = (w[13:8] == 6'h0f) || (w[13:8] == 6'h0a);
    instr_word <= w;
    reg_rdata <= d;
    instr_valid <= 1'b1;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    chk("discard", sk, discard_reg);
    chk("ready", !sk, instr_ready);
    chk("raddr", w[6:0], reg_raddr);
    chk("pc_load", jp, pc_load_reg);
    chk("reg_we", ic && w[7], reg_we_reg);
    chk("wacc_we", ic && !w[7], wacc_we_reg);
    chk("zero_we", w[13:8] == 6'h0a, zero_we_reg);
    chk("unknown", !jp && !ic, unknown_reg);
    if (ic) chk("result", r, result_reg);
    @(posedge clock);
  endtask
  // Near misses of the jump and increment codes are not decoded
  task automatic t_other;
    op(14'h2555, 8'hff, 8'h00, 1'b0);
    op(14'h0b12, 8'hff, 8'h00, 1'b0);
    $display("unhandled word test done");
  endtask
  task automatic t_reset;
    arst_n <= 1'b0;
    @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk("rst_target", 13'h0000, pc_target_reg);
    chk("rst_result", 8'h00, result_reg);
    chk("rst_ready", 1'b1, instr_ready);
    @(posedge clock);
    $display("reset test done");
  endtask
  task automatic t_jump;
    upper_page_latch <= 5'h08;
    op(14'h2d55, 8'h00, 8'h00, 1'b1);
    chk("target", 13'h0d55, pc_target_reg);
    $display("jump test done");
  endtask
  task automatic t_skip;
    op(14'h0f92, 8'hff, 8'h00, 1'b1);
    chk("waddr", 7'h12, reg_waddr_reg);
    op(14'h0f12, 8'h12, 8'h13, 1'b0);
    $display("skip test done");
  endtask
  task automatic t_inc;
    op(14'h0a12, 8'hff, 8'h00, 1'b0);
    chk("zero", 1'b1, zero_val_reg);
    op(14'h0a92, 8'h41, 8'h42, 1'b0);
    chk("zero", 1'b0, zero_val_reg);
    $display("increment test done");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    t_jump();
    t_skip();
    t_inc();
    t_other();
    t_reset();
    conclude();
  end
  // Whole run needs about 20 cycles
  initial begin
    #2000;
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
